/* File: core/cirq_pkg.sv */
// Constants for the common register and interrupt block.
// Assumes a 40 MHz core clock and a byte-wide host register port.
package cirq_pkg;

    // ****************
    // Register offsets
    // ****************
    localparam logic [15:0] GATEWAY_OFF     = 16'h0001;
    localparam logic [15:0] SUBNET_OFF      = 16'h0005;
    localparam logic [15:0] MAC_OFF         = 16'h0009;
    localparam logic [15:0] SRC_IP_OFF      = 16'h000f;
    localparam logic [15:0] ASSERT_WAIT_OFF = 16'h0013;
    localparam logic [15:0] INT_STATUS_OFF  = 16'h0015;
    localparam logic [15:0] INT_MASK_OFF    = 16'h0016;
    localparam logic [15:0] SOCK_STAT_OFF   = 16'h0017;
    localparam logic [15:0] SOCK_MASK_OFF   = 16'h0018;
    localparam logic [15:0] RETRY_TIME_OFF  = 16'h0019;
    localparam logic [15:0] RETRY_COUNT_OFF = 16'h001b;
    localparam logic [15:0] ICMP_NO_PORT_FLAG_IP_OFF  = 16'h0028;
    localparam logic [15:0] ICMP_NO_PORT_FLAG_PT_OFF  = 16'h002c;

    // ****************
    // Register sizes in bytes
    // ****************
    localparam int ADDR_BYTES = 4;
    localparam int MAC_BYTES  = 6;
    localparam int HALF_BYTES = 2;

    // ****************
    // Reset values
    // ****************
    localparam logic [31:0] ADDR_RST        = 32'h0000_0000;
    localparam logic [47:0] MAC_RST         = 48'h0000_0000_0000;
    localparam logic [15:0] ASSERT_WAIT_RST = 16'h0000;
    localparam logic [7:0]  BYTE_RST        = 8'h00;
    localparam logic [15:0] RETRY_TIME_RST  = 16'h07d0;
    localparam logic [7:0]  RETRY_COUNT_RST = 8'h08;

    // ****************
    // Interrupt status field positions
    // ****************
    localparam int IP_CLASH_BIT  = 7;
    localparam int NO_PORT_BIT   = 6;
    localparam int SESS_CLS_BIT  = 5;
    localparam int MAGIC_PKT_BIT = 4;
    localparam logic [7:0] INT_IMPL_MASK = 8'hf0;

    // ****************
    // Timing
    // ****************
    localparam int CLK_PERIOD_NS   = 25;
    localparam int RETRY_UNIT_NS   = 100000;
    localparam int RETRY_UNIT_CYC  = (RETRY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ASSERT_WAIT_MUL = 4;
    localparam logic [16:0] RETRY_WAIT_MAX = 17'h0ffff;

    // ****************
    // State types
    // ****************
    typedef enum logic [1:0] {
        PIN_IDLE = 2'b00,
        PIN_WAIT = 2'b01,
        PIN_LOW  = 2'b11
    } cirq_pin_t;

    typedef enum logic {
        RTY_IDLE = 1'b0,
        RTY_WAIT = 1'b1
    } cirq_retry_t;

endpackage

/* File: core/cirq_common_regs.sv */
// Common registers, chip interrupt pin and retransmission timer.
// Assumes the host port and event sources run on mclk_in.
//
// Summary of operation
// - Gateway address at 0x0001-0x0004, cleared at reset
// - Subnet mask at 0x0005-0x0008, cleared at reset
// - Hardware address and own IP, host writable
// - Pin asserts after (setting+1)*4 clocks wait, at once for setting 0
// - Second pending interrupt keeps pin low
// - Clear with other pending: high for wait, stays low for setting 0
// - Write one clears flags; pin follows enabled
// - Bit 7 set on IP address clash
// - Bit 6 on port unreachable, capture address
// - Bit 5 on session close in PPPoE
// - Bit 4 on magic packet; bits 3-0 reserved
// - Mask bit gates each chip flag
// - Socket summary bit follows socket flags
// - Socket mask gates each summary bit
// - Retry time counts 100 us units
// - Wait retry time after command, then act
// - Timeout after count plus one expiries
// - ARP resend each interval, count times
// - TCP wait doubles, held below 65536
// - TCP final timeout raises timeout pulse
// - Magic packet needs wake packet mode
`timescale 1ns/1ps

module cirq_common_regs (
    input  wire logic        mclk_in,
    input  wire logic        reset_in,
    input  wire logic [15:0] reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    input  wire logic        ip_clash_evt_in,
    input  wire logic        no_port_evt_in,
    input  wire logic [31:0] unreachable_ip_in,
    input  wire logic [15:0] unreachable_port_in,
    input  wire logic        session_close_evt_in,
    input  wire logic        pppoe_mode_in,
    input  wire logic        magic_packet_evt_in,
    input  wire logic        wake_packet_mode_in,
    input  wire logic [7:0]  socket_pending_bit_in,
    input  wire logic        retry_start_in,
    input  wire logic        retry_tcp_in,
    input  wire logic        peer_reply_in,
    output logic             retransmit_out,
    output logic             timeout_out,
    output logic             interrupt_pin_low_out,
    output logic      [31:0] gateway_address_out,
    output logic      [31:0] subnet_mask_out,
    output logic      [47:0] source_mac_address_out,
    output logic      [31:0] source_ip_address_out
);
    import cirq_pkg::*;

    // ****************
    // Helper functions
    // ****************

    // True when addr falls inside a register of len bytes at base
    function automatic logic in_range(input logic [15:0] addr, input logic [15:0] base,
                                      input int len);
        in_range = (addr >= base) && (addr < base + 16'(len));
    endfunction

    // Bit position of the addressed byte, first offset holds the top byte
    function automatic int byte_pos(input logic [15:0] addr, input logic [15:0] base,
                                    input int len);
        byte_pos = 8 * (len - 1 - int'(addr - base));
    endfunction

    // ****************
    // Storage
    // ****************
    logic [31:0] gateway_r;
    logic [31:0] subnet_r;
    logic [47:0] mac_r;
    logic [31:0] src_ip_r;
    logic [15:0] assert_wait_r;
    logic [7:0]  int_status_r;
    logic [7:0]  int_mask_r;
    logic [7:0]  sock_stat_r;
    logic [7:0]  sock_mask_r;
    logic [15:0] retry_time_r;
    logic [7:0]  retry_count_r;
    logic [31:0] icmp_no_port_flag_ip_r;
    logic [15:0] icmp_no_port_flag_port_r;

    logic        wr_gw;
    logic        wr_sn;
    logic        wr_mac;
    logic        wr_ip;
    logic        wr_aw;
    logic        wr_rt;
    logic        wr_is;
    logic [7:0]  int_clear;
    logic [7:0]  int_set;

    // Write decode of the host port
    always_comb begin
        wr_gw = reg_wr_in && in_range(reg_addr_in, GATEWAY_OFF, ADDR_BYTES);
        wr_sn = reg_wr_in && in_range(reg_addr_in, SUBNET_OFF, ADDR_BYTES);
        wr_mac = reg_wr_in && in_range(reg_addr_in, MAC_OFF, MAC_BYTES);
        wr_ip = reg_wr_in && in_range(reg_addr_in, SRC_IP_OFF, ADDR_BYTES);
        wr_aw = reg_wr_in && in_range(reg_addr_in, ASSERT_WAIT_OFF, HALF_BYTES);
        wr_rt = reg_wr_in && in_range(reg_addr_in, RETRY_TIME_OFF, HALF_BYTES);
        wr_is = reg_wr_in && (reg_addr_in == INT_STATUS_OFF);
    end

    // Address registers
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            gateway_r <= ADDR_RST;
            subnet_r  <= ADDR_RST;
            mac_r     <= MAC_RST;
            src_ip_r  <= ADDR_RST;
        end else if (wr_gw) begin
            gateway_r[byte_pos(reg_addr_in, GATEWAY_OFF, ADDR_BYTES) +: 8] <= reg_wdata_in;
        end else if (wr_sn) begin
            subnet_r[byte_pos(reg_addr_in, SUBNET_OFF, ADDR_BYTES) +: 8] <= reg_wdata_in;
        end else if (wr_mac) begin
            mac_r[byte_pos(reg_addr_in, MAC_OFF, MAC_BYTES) +: 8] <= reg_wdata_in;
        end else if (wr_ip) begin
            src_ip_r[byte_pos(reg_addr_in, SRC_IP_OFF, ADDR_BYTES) +: 8] <= reg_wdata_in;
        end
    end

    // Timer and mask settings
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            assert_wait_r <= ASSERT_WAIT_RST;
            int_mask_r    <= BYTE_RST;
            sock_mask_r   <= BYTE_RST;
            retry_time_r  <= RETRY_TIME_RST;
            retry_count_r <= RETRY_COUNT_RST;
        end else if (wr_aw) begin
            assert_wait_r[byte_pos(reg_addr_in, ASSERT_WAIT_OFF, HALF_BYTES) +: 8]
                <= reg_wdata_in;
        end else if (wr_rt) begin
            retry_time_r[byte_pos(reg_addr_in, RETRY_TIME_OFF, HALF_BYTES) +: 8]
                <= reg_wdata_in;
        end else if (reg_wr_in && reg_addr_in == INT_MASK_OFF) begin
            int_mask_r <= reg_wdata_in & INT_IMPL_MASK;
        end else if (reg_wr_in && reg_addr_in == SOCK_MASK_OFF) begin
            sock_mask_r <= reg_wdata_in;
        end else if (reg_wr_in && reg_addr_in == RETRY_COUNT_OFF) begin
            retry_count_r <= reg_wdata_in;
        end
    end

    // ****************
    // Interrupt flags
    // ****************

    // Event sources for the chip flags
    always_comb begin
        int_set = BYTE_RST;
        int_set[IP_CLASH_BIT]  = ip_clash_evt_in;
        int_set[NO_PORT_BIT]   = no_port_evt_in;
        int_set[SESS_CLS_BIT]  = session_close_evt_in && pppoe_mode_in;
        int_set[MAGIC_PKT_BIT] = magic_packet_evt_in && wake_packet_mode_in;
        int_clear = wr_is ? (reg_wdata_in & INT_IMPL_MASK) : BYTE_RST;
    end

    // Sticky flags, a set in the clearing cycle wins
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            int_status_r <= BYTE_RST;
        end else begin
            int_status_r <= ((int_status_r & ~int_clear) | int_set) & INT_IMPL_MASK;
        end
    end

    // Destination of the last unreachable report
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            icmp_no_port_flag_ip_r   <= ADDR_RST;
            icmp_no_port_flag_port_r <= ASSERT_WAIT_RST;
        end else if (no_port_evt_in) begin
            icmp_no_port_flag_ip_r   <= unreachable_ip_in;
            icmp_no_port_flag_port_r <= unreachable_port_in;
        end
    end

    // Socket summary follows the per-socket flag state
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            sock_stat_r <= BYTE_RST;
        end else begin
            sock_stat_r <= socket_pending_bit_in;
        end
    end

    // ****************
    // Interrupt pin sequencing
    // ****************
    cirq_pin_t   pin_state_r;
    cirq_pin_t   pin_state_nxt;
    logic [18:0] wait_cnt_r;
    logic [18:0] wait_load;
    logic        pending;
    logic        handled;

    // Enabled pending sources and host handling of one of them
    always_comb begin
        pending = |(int_status_r & int_mask_r) | |(sock_stat_r & sock_mask_r);
        handled = |(int_clear & int_status_r) | |(sock_stat_r & ~socket_pending_bit_in);
        wait_load = (19'(assert_wait_r) + 19'd1) * 19'(ASSERT_WAIT_MUL);
    end

    // Next pin state
    always_comb begin
        pin_state_nxt = pin_state_r;
        case (pin_state_r)
            PIN_IDLE: begin
                if (pending) begin
                    pin_state_nxt = (assert_wait_r == ASSERT_WAIT_RST) ? PIN_LOW : PIN_WAIT;
                end
            end
            PIN_WAIT: begin
                if (!pending) begin
                    pin_state_nxt = PIN_IDLE;
                end else if (wait_cnt_r <= 19'd1) begin
                    pin_state_nxt = PIN_LOW;
                end
            end
            PIN_LOW: begin
                if (!pending) begin
                    pin_state_nxt = PIN_IDLE;
                end else if (handled && assert_wait_r != ASSERT_WAIT_RST) begin
                    pin_state_nxt = PIN_WAIT;
                end
            end
            default: begin
                pin_state_nxt = PIN_IDLE;
            end
        endcase
    end

    // Pin state and wait counter
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            pin_state_r <= PIN_IDLE;
            wait_cnt_r  <= 19'd0;
        end else begin
            pin_state_r <= pin_state_nxt;
            if (pin_state_nxt == PIN_WAIT && pin_state_r != PIN_WAIT) begin
                wait_cnt_r <= wait_load;
            end else if (wait_cnt_r != 19'd0) begin
                wait_cnt_r <= wait_cnt_r - 19'd1;
            end
        end
    end

    // Active-low pin, held low while pending in PIN_LOW
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            interrupt_pin_low_out <= 1'b1;
        end else begin
            interrupt_pin_low_out <= (pin_state_nxt != PIN_LOW);
        end
    end

    // ****************
    // Retransmission timer
    // ****************
    cirq_retry_t rty_state_r;
    logic [11:0] unit_cnt_r;
    logic [15:0] units_left_r;
    logic [15:0] cur_wait_r;
    logic [8:0]  expiry_cnt_r;
    logic        tcp_mode_r;
    logic        unit_tick;
    logic        expire;
    logic [16:0] doubled;

    // Unit tick, expiry and doubled wait
    always_comb begin
        unit_tick = (unit_cnt_r == 12'(RETRY_UNIT_CYC - 1));
        expire    = (rty_state_r == RTY_WAIT) && unit_tick && (units_left_r <= 16'd1);
        doubled   = {cur_wait_r, 1'b0};
    end

    // Retry sequencer
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            rty_state_r    <= RTY_IDLE;
            unit_cnt_r     <= 12'd0;
            units_left_r   <= 16'd0;
            cur_wait_r     <= 16'd0;
            expiry_cnt_r   <= 9'd0;
            tcp_mode_r     <= 1'b0;
            retransmit_out <= 1'b0;
            timeout_out    <= 1'b0;
        end else begin
            retransmit_out <= 1'b0;
            timeout_out    <= 1'b0;
            unit_cnt_r     <= unit_tick ? 12'd0 : unit_cnt_r + 12'd1;
            case (rty_state_r)
                RTY_IDLE: begin
                    if (retry_start_in) begin
                        rty_state_r  <= RTY_WAIT;
                        unit_cnt_r   <= 12'd0;
                        units_left_r <= retry_time_r;
                        cur_wait_r   <= retry_time_r;
                        expiry_cnt_r <= 9'd0;
                        tcp_mode_r   <= retry_tcp_in;
                    end
                end
                RTY_WAIT: begin
                    if (peer_reply_in) begin
                        rty_state_r <= RTY_IDLE;
                    end else if (expire) begin
                        if (expiry_cnt_r == {1'b0, retry_count_r}) begin
                            timeout_out <= 1'b1;
                            rty_state_r <= RTY_IDLE;
                        end else begin
                            retransmit_out <= 1'b1;
                            expiry_cnt_r   <= expiry_cnt_r + 9'd1;
                            if (tcp_mode_r && doubled <= RETRY_WAIT_MAX) begin
                                cur_wait_r   <= doubled[15:0];
                                units_left_r <= doubled[15:0];
                            end else begin
                                units_left_r <= cur_wait_r;
                            end
                        end
                    end else if (unit_tick) begin
                        units_left_r <= units_left_r - 16'd1;
                    end
                end
                default: begin
                    rty_state_r <= RTY_IDLE;
                end
            endcase
        end
    end

    // ****************
    // Read path
    // ****************

    // Registered read data, zero for unmapped offsets
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            reg_rdata_out <= BYTE_RST;
        end else if (!reg_rd_in) begin
            reg_rdata_out <= BYTE_RST;
        end else if (in_range(reg_addr_in, GATEWAY_OFF, ADDR_BYTES)) begin
            reg_rdata_out <= gateway_r[byte_pos(reg_addr_in, GATEWAY_OFF, ADDR_BYTES) +: 8];
        end else if (in_range(reg_addr_in, SUBNET_OFF, ADDR_BYTES)) begin
            reg_rdata_out <= subnet_r[byte_pos(reg_addr_in, SUBNET_OFF, ADDR_BYTES) +: 8];
        end else if (in_range(reg_addr_in, MAC_OFF, MAC_BYTES)) begin
            reg_rdata_out <= mac_r[byte_pos(reg_addr_in, MAC_OFF, MAC_BYTES) +: 8];
        end else if (in_range(reg_addr_in, SRC_IP_OFF, ADDR_BYTES)) begin
            reg_rdata_out <= src_ip_r[byte_pos(reg_addr_in, SRC_IP_OFF, ADDR_BYTES) +: 8];
        end else if (in_range(reg_addr_in, ASSERT_WAIT_OFF, HALF_BYTES)) begin
            reg_rdata_out <=
                assert_wait_r[byte_pos(reg_addr_in, ASSERT_WAIT_OFF, HALF_BYTES) +: 8];
        end else if (reg_addr_in == INT_STATUS_OFF) begin
            reg_rdata_out <= int_status_r;
        end else if (reg_addr_in == INT_MASK_OFF) begin
            reg_rdata_out <= int_mask_r;
        end else if (reg_addr_in == SOCK_STAT_OFF) begin
            reg_rdata_out <= sock_stat_r;
        end else if (reg_addr_in == SOCK_MASK_OFF) begin
            reg_rdata_out <= sock_mask_r;
        end else if (in_range(reg_addr_in, RETRY_TIME_OFF, HALF_BYTES)) begin
            reg_rdata_out <=
                retry_time_r[byte_pos(reg_addr_in, RETRY_TIME_OFF, HALF_BYTES) +: 8];
        end else if (reg_addr_in == RETRY_COUNT_OFF) begin
            reg_rdata_out <= retry_count_r;
        end else if (in_range(reg_addr_in, ICMP_NO_PORT_FLAG_IP_OFF, ADDR_BYTES)) begin
            reg_rdata_out <=
                icmp_no_port_flag_ip_r[byte_pos(reg_addr_in, ICMP_NO_PORT_FLAG_IP_OFF, ADDR_BYTES) +: 8];
        end else if (in_range(reg_addr_in, ICMP_NO_PORT_FLAG_PT_OFF, HALF_BYTES)) begin
            reg_rdata_out <=
                icmp_no_port_flag_port_r[byte_pos(reg_addr_in, ICMP_NO_PORT_FLAG_PT_OFF, HALF_BYTES) +: 8];
        end else begin
            reg_rdata_out <= BYTE_RST;
        end
    end

    // Configured addresses for the protocol engines
    always_comb begin
        gateway_address_out    = gateway_r;
        subnet_mask_out        = subnet_r;
        source_mac_address_out = mac_r;
        source_ip_address_out  = src_ip_r;
    end

endmodule // cirq_common_regs

/* File: testbench/cirq_common_regs_monitor.sv */
// Port checker for the common register and interrupt block.
// Assumes it is bound to cirq_common_regs on a single mclk_in domain.
`timescale 1ns/1ps
module cirq_common_regs_monitor
    import cirq_pkg::*;
(
    input wire logic        mclk_in,
    input wire logic        reset_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        retransmit_out,
    input wire logic        timeout_out,
    input wire logic [31:0] gateway_address_out,
    input wire logic [31:0] subnet_mask_out,
    input wire logic [47:0] source_mac_address_out,
    input wire logic [31:0] source_ip_address_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    // ****************
    // Host access steps
    // ****************
    sequence s_wr(logic [15:0] a);
        reg_wr_in && reg_addr_in == a;
    endsequence
    sequence s_rd(logic [15:0] a);
        reg_rd_in && reg_addr_in == a;
    endsequence
    a_rdata_idle_zero: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data not zero without a read");
    a_gateway_msb_first: assert property (s_wr(GATEWAY_OFF) |=>
        gateway_address_out[31:24] == $past(reg_wdata_in)) else $error("gateway byte wrong");
    a_subnet_last_byte: assert property (s_wr(SUBNET_OFF + 16'h0003) |=>
        subnet_mask_out[7:0] == $past(reg_wdata_in)) else $error("subnet byte wrong");
    a_mac_first_byte: assert property (s_wr(MAC_OFF) |=>
        source_mac_address_out[47:40] == $past(reg_wdata_in)) else $error("mac byte wrong");
    a_ip_last_byte: assert property (s_wr(SRC_IP_OFF + 16'h0003) |=>
        source_ip_address_out[7:0] == $past(reg_wdata_in)) else $error("ip byte wrong");
    a_status_low_reserved: assert property (s_rd(INT_STATUS_OFF) |=>
        reg_rdata_out[3:0] == 4'h0) else $error("reserved status bits set");
    a_unmapped_reads_zero: assert property (s_rd(16'h0030) |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_timeout_one_cycle: assert property (timeout_out |=> !timeout_out)
        else $error("timeout pulse too long");
    a_resend_gap: assert property (retransmit_out |=>
        (!retransmit_out && !timeout_out)[*8]) else $error("retry interval too short");
endmodule // cirq_common_regs_monitor

bind cirq_common_regs cirq_common_regs_monitor u_mon (.*);

/* File: testbench/cirq_host.sv */
// Host side model: byte reads and writes on the register port.
// Assumes tasks are called from the bench; each access waits for its own edge.
`timescale 1ns/1ps
module cirq_host (
    input  wire logic        mclk_in,
    input  wire logic [7:0]  rdata_in,
    output logic      [15:0] addr_out,
    output logic      [7:0]  wdata_out,
    output logic             wr_out,
    output logic             rd_out
);
    // Idle bus shows no stale value
    initial begin
        addr_out = 16'hffff;
        wdata_out = 8'hff;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // One byte write, held through the taking edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        #1;
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(posedge mclk_in);
        #1;
        wr_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
    endtask
    // One byte read, data taken the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        #1;
        addr_out = a;
        rd_out = 1'b1;
        @(posedge mclk_in);
        #1;
        rd_out = 1'b0;
        addr_out = ~a;
        d = rdata_in;
    endtask
endmodule // cirq_host

/* File: testbench/common_irq_and_retry_regs_bench.sv */
// Self-checking bench for the common register and interrupt block.
// Assumes a 40 MHz clock and the host model on the register port.
`timescale 1ns/1ps
module common_irq_and_retry_regs_bench;
    import cirq_pkg::*;
    logic        mclk, rst, pppoe, wake, tcp, pin, rt, tmo;
    logic [5:0]  ev;
    logic [7:0]  sock, rdata, wd, d;
    logic [15:0] addr, uport;
    logic [31:0] uip, gw, sm, ip;
    logic [47:0] mac;
    logic        wr, rd;
    int          errors, n_checks, n, m;
    cirq_host host (.mclk_in(mclk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wd),
        .wr_out(wr), .rd_out(rd));
    cirq_common_regs dut (.mclk_in(mclk), .reset_in(rst), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .ip_clash_evt_in(ev[0]), .no_port_evt_in(ev[1]), .unreachable_ip_in(uip),
        .unreachable_port_in(uport), .session_close_evt_in(ev[2]), .pppoe_mode_in(pppoe),
        .magic_packet_evt_in(ev[3]), .wake_packet_mode_in(wake),
        .socket_pending_bit_in(sock), .retry_start_in(ev[4]), .retry_tcp_in(tcp),
        .peer_reply_in(ev[5]), .retransmit_out(rt), .timeout_out(tmo),
        .interrupt_pin_low_out(pin), .gateway_address_out(gw), .subnet_mask_out(sm),
        .source_mac_address_out(mac), .source_ip_address_out(ip));
    // ****************
    // Helpers
    // ****************
    task automatic chk_val(string nm, logic [47:0] e, logic [47:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_rng(string nm, int lo, int hi, int g);
        n_checks++;
        if (g < lo || g > hi) begin
            errors++;
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    task automatic rchk(logic [15:0] a, logic [7:0] e);
        host.rd(a, d);
        chk_val($sformatf("reg %h", a), e, d);
    endtask
    task automatic wr_n(logic [15:0] a, logic [47:0] v, int len);
        for (int i = 0; i < len; i++) host.wr(a + i[15:0], v[8*(len-1-i) +: 8]);
    endtask
    task automatic pulse(int k);
        @(posedge mclk);
        #1 ev[k] = 1'b1;
        @(posedge mclk);
        #1 ev[k] = 1'b0;
    endtask
    task automatic wait_pin(logic v, output int c);
        for (c = 0; pin !== v && c < 100; c++) @(posedge mclk) #1;
    endtask
    task automatic cnt_low(int len, output int c);
        c = 0;
        repeat (len) @(posedge mclk) #1 c += (pin === 1'b0);
    endtask
    task automatic wait_tmo(int lim, output int r, output int c);
        r = 0;
        for (c = 0; tmo !== 1'b1 && c < lim; c++) @(posedge mclk) #1 r += (rt === 1'b1);
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        for (int i = 0; i <= 28; i++) rchk(i[15:0], (i == 25) ? RETRY_TIME_RST[15:8] :
            (i == 26) ? RETRY_TIME_RST[7:0] : (i == 27) ? RETRY_COUNT_RST : 8'h00);
        chk_val("pin", 1, pin);
    endtask
    task automatic t_addr();
        wr_n(GATEWAY_OFF, 48'hc0a80001, 4);
        wr_n(SUBNET_OFF, 48'hffffff00, 4);
        wr_n(MAC_OFF, 48'h0008dc010203, 6);
        wr_n(SRC_IP_OFF, 48'hc0a80002, 4);
        host.wr(SOCK_STAT_OFF, 8'hff);
        host.wr(16'h0030, 8'h5a);
        chk_val("gateway", 32'hc0a80001, gw);
        chk_val("subnet", 32'hffffff00, sm);
        chk_val("mac", 48'h0008dc010203, mac);
        chk_val("ip", 32'hc0a80002, ip);
        rchk(GATEWAY_OFF + 16'h0003, 8'h01);
        rchk(MAC_OFF + 16'h0002, 8'hdc);
        rchk(SOCK_STAT_OFF, 8'h00);
        rchk(16'h0030, 8'h00);
    endtask
    task automatic t_flags();
        logic [47:0] u;
        host.wr(INT_MASK_OFF, 8'hff);
        rchk(INT_MASK_OFF, 8'hf0);
        pulse(0);
        wait_pin(0, n);
        chk_rng("pin delay s0", 1, 3, n);
        rchk(INT_STATUS_OFF, 8'h80);
        host.wr(INT_STATUS_OFF, 8'h8f);
        wait_pin(1, n);
        chk_rng("pin release", 0, 2, n);
        host.wr(INT_MASK_OFF, 8'h00);
        pulse(3);
        pulse(2);
        wake = 1'b1;
        pppoe = 1'b1;
        pulse(3);
        rchk(INT_STATUS_OFF, 8'h10);
        pulse(2);
        pulse(1);
        rchk(INT_STATUS_OFF, 8'h70);
        cnt_low(10, n);
        chk_rng("masked pin", 0, 0, n);
        u = {uip, uport};
        for (int i = 0; i < 6; i++) rchk(ICMP_NO_PORT_FLAG_IP_OFF + i[15:0], u[8*(5-i) +: 8]);
        host.wr(INT_STATUS_OFF, 8'h70);
        rchk(INT_STATUS_OFF, 8'h00);
    endtask
    task automatic t_wait();
        wr_n(ASSERT_WAIT_OFF, 48'h0001, 2);
        host.wr(INT_MASK_OFF, 8'h80);
        host.wr(SOCK_MASK_OFF, 8'h01);
        pulse(0);
        wait_pin(0, n);
        chk_rng("pin wait s1", 7, 10, n);
        sock = 8'h01;
        cnt_low(10, n);
        chk_rng("pin held", 10, 10, n);
        rchk(SOCK_STAT_OFF, 8'h01);
        host.wr(INT_STATUS_OFF, 8'h80);
        wait_pin(1, n);
        wait_pin(0, m);
        chk_rng("re-wait", 6, 10, m);
        sock = 8'h02;
        wait_pin(1, n);
        chk_rng("socket drop", 0, 3, n);
        cnt_low(20, n);
        chk_rng("socket masked", 0, 0, n);
        sock = 8'h00;
    endtask
    task automatic t_retry();
        wr_n(RETRY_TIME_OFF, 48'h0001, 2);
        host.wr(RETRY_COUNT_OFF, 8'h01);
        pulse(4);
        pulse(4);
        wait_tmo(40000, m, n);
        chk_rng("arp total", 7990, 8006, n);
        chk_rng("arp resends", 1, 1, m);
        host.wr(RETRY_COUNT_OFF, 8'h02);
        tcp = 1'b1;
        pulse(4);
        wait_tmo(40000, m, n);
        chk_rng("tcp total", 27994, 28006, n);
        chk_rng("tcp resends", 2, 2, m);
        tcp = 1'b0;
        pulse(4);
        pulse(5);
        wait_tmo(6000, m, n);
        chk_rng("aborted", 6000, 6000, n);
    endtask
    // ****************
    // Clock, run and verdict
    // ****************
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic test_done();
        if (errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #(60000 * 25);
        errors++;
        test_done();
    end
    initial begin
        {pppoe, wake, tcp, ev, sock} = '0;
        uip = 32'hc0a8000b;
        uport = 16'h1234;
        errors = 0;
        n_checks = 0;
        rst = 1'b1;
        repeat (12) @(posedge mclk);
        #1 rst = 1'b0;
        t_reset();
        t_addr();
        t_flags();
        t_wait();
        t_retry();
        test_done();
    end
endmodule // common_irq_and_retry_regs_bench
